// file: logic/lpw_pkg.sv
// Purpose: shared constants and types for the low-power wake controller
// Assumes: sys_clk at 100 MHz; wake pins and alarms idle high, request low; usb wake idle low, request high
// Notes:   settle and startup cycle counts are derived from times in ns; RESYNC_CYC is a plain count

package lpw_pkg;

    // clock
    localparam int CLK_PERIOD_NS   = 10;

    // wake source layout: 16 pins, then supply monitor, calendar, timer
    localparam int NUM_FAST_PINS   = 16;
    localparam int NUM_WAKE        = 19;
    localparam int WAKE_IDX_SM     = 16;
    localparam int WAKE_IDX_RTC    = 17;
    localparam int WAKE_IDX_RTT    = 18;
    localparam int SYNC_W          = 20;   // 19 wake lines plus usb wake
    localparam int SYNC_IDX_USB    = 19;

    // timing: oscillator settle (least time, rounds up), startup bound (longest, rounds down)
    localparam int RC_SETTLE_NS    = 5000;
    localparam int RC_SETTLE_CYC   = (RC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_MAX_NS  = 10000;
    localparam int STARTUP_MAX_CYC = STARTUP_MAX_NS / CLK_PERIOD_NS;
    localparam int RESYNC_CYC      = 4;

    // counters
    localparam int CNT_W           = 11;
    localparam int DEB_CNT_W       = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

    // values after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 20'h7_FFFF;  // lines idle high, usb wake idle low
    localparam logic              DEB_LEVEL_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP_WFI,
        ST_SLEEP_WFE,
        ST_WAIT_SYNC,
        ST_WAIT,
        ST_RESTART,
        ST_BACKUP
    } lpw_state_type;

endpackage

// file: logic/lpw_wake_if.sv
// Purpose: carries the synchronised wake lines between modules
// Assumes: one producer, one consumer on sys_clk
// Notes:   bits 0..18 active low wake lines, bit 19 usb wake active high

`timescale 1ns/1ps

interface lpw_wake_if;
    import lpw_pkg::*;
    logic [SYNC_W-1:0] lines_sync;
    modport prod (output lines_sync);
    modport cons (input  lines_sync);
endinterface

// file: logic/lpw_sync.sv
// Purpose: two-flop synchroniser for the asynchronous wake lines
// Assumes: inputs change at any time relative to sys_clk
// Notes:   the first stage feeds only the second stage

`timescale 1ns/1ps

module lpw_sync
    import lpw_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    // raw lines and synchronised result
    input  wire logic [SYNC_W-1:0] async_in,
    lpw_wake_if.prod               wif
);
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] next_stage1;
    logic [SYNC_W-1:0] next_stage2;

    // next values: straight shift
    always_comb begin
        next_stage1 = async_in;
        next_stage2 = stage1;
    end

    // reset to idle levels so no false wake at start
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stage1 <= SYNC_RST;
            stage2 <= SYNC_RST;
        end else if (clk_en) begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign wif.lines_sync = stage2;

endmodule

// file: logic/lpw_debounce.sv
// Purpose: debounce one synchronised wake pin and flag its transitions
// Assumes: input already synchronised to sys_clk
// Notes:   limit of zero accepts a change on the first differing cycle

`timescale 1ns/1ps

module lpw_debounce
    import lpw_pkg::*;
#(
    parameter int CW = DEB_CNT_W
)
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          clk_en,
    // pin and setting
    input  wire logic          pin_sync,
    input  wire logic [CW-1:0] limit,
    // result
    output logic               level,
    output logic               change
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_level;
    logic          next_change;

    // count while the pin differs from the accepted level
    always_comb begin
        next_cnt    = '0;
        next_level  = level;
        next_change = 1'b0;
        if (pin_sync != level) begin
            if (cnt >= limit) begin
                next_level  = pin_sync;
                next_change = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt    <= '0;
            level  <= DEB_LEVEL_RST;
            change <= 1'b0;
        end else if (clk_en) begin
            cnt    <= next_cnt;
            level  <= next_level;
            change <= next_change;
        end
    end

endmodule

// file: logic/lpw_top.sv
// Purpose: sleep, wait and backup sequencing with fast wake restart
// Assumes: sys_clk is the always-on control clock; gated clocks are outputs
// Notes:   fast_startup_req is combinational on purpose, it must work clockless

`timescale 1ns/1ps

module lpw_top
    import lpw_pkg::*;
#(
    parameter int IO_W = 32
)
(
    // clock, reset, enable
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    input  wire logic                       clk_en,
    // processor core, same clock
    input  wire logic                       wait_for_event_instr,
    input  wire logic                       wait_for_interrupt_instr,
    input  wire logic                       irq_pending,
    input  wire logic                       event_pending,
    // configuration levels
    input  wire logic                       low_power_select,
    input  wire logic [NUM_WAKE-1:0]        fast_startup_mode_reg,
    input  wire logic                       usb_wake_enable,
    input  wire logic [NUM_FAST_PINS-1:0]   wake_pin_enable,
    input  wire logic [DEB_CNT_W-1:0]       debounce_limit,
    input  wire logic                       backup_enter,
    input  wire logic                       io_release,
    // asynchronous wake sources
    input  wire logic [NUM_FAST_PINS-1:0]   fast_wake_lines,
    input  wire logic                       supply_monitor_alarm,
    input  wire logic                       rtc_alarm,
    input  wire logic                       real_time_timer_alarm,
    input  wire logic                       usb_wake,
    // pad side of the I/O controller
    input  wire logic [IO_W-1:0]            io_out_req,
    input  wire logic [IO_W-1:0]            io_oe_req,
    output logic      [IO_W-1:0]            io_out,
    output logic      [IO_W-1:0]            io_oe,
    output logic      [IO_W-1:0]            io_pullup,
    // clock control
    output logic                            core_clk_en,
    output logic                            periph_clk_en,
    output logic                            mem_clk_en,
    output logic                            rc_osc_on,
    output logic                            main_clk_sel_rc,
    output logic                            fast_rc_osc_enable,
    // status
    output logic                            fast_startup_req,
    output logic                            in_sleep,
    output logic                            in_wait,
    output logic                            in_backup,
    output logic                            backup_wake
);

    ////////////////////////////////////////////////////////////////////////////
    // wake line synchronisation and debounce

    lpw_wake_if wif ();

    lpw_sync u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .async_in ({usb_wake, real_time_timer_alarm, rtc_alarm,
                    supply_monitor_alarm, fast_wake_lines}),
        .wif      (wif.prod)
    );

    logic [NUM_FAST_PINS-1:0] deb_level;
    logic [NUM_FAST_PINS-1:0] deb_change;

    // one debouncer per backup wake pin
    for (genvar i = 0; i < NUM_FAST_PINS; i++) begin : g_deb
        lpw_debounce u_deb (
            .sys_clk  (sys_clk),
            .rstn     (rstn),
            .clk_en   (clk_en),
            .pin_sync (wif.lines_sync[i]),
            .limit    (debounce_limit),
            .level    (deb_level[i]),
            .change   (deb_change[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake decode

    logic [NUM_WAKE-1:0] wake_lines_sync;
    logic                fast_wake_sync;
    logic                wait_wake;
    logic                alarm_low_sync;
    logic                backup_wake_hit;

    assign wake_lines_sync = wif.lines_sync[NUM_WAKE-1:0];

    // clockless path straight from the pads for the oscillator start
    assign fast_startup_req = |(~{real_time_timer_alarm, rtc_alarm, supply_monitor_alarm,
                                  fast_wake_lines} & fast_startup_mode_reg);

    // synchronised copy drives the sequencer, avoiding glitchy switching
    assign fast_wake_sync = |(~wake_lines_sync & fast_startup_mode_reg);

    // any enabled source ends the wait state, usb included
    assign wait_wake = fast_wake_sync | (usb_wake_enable & wif.lines_sync[SYNC_IDX_USB]);

    // monitor and alarms wake from backup on low level
    assign alarm_low_sync = ~wake_lines_sync[WAKE_IDX_SM] |
                            ~wake_lines_sync[WAKE_IDX_RTC] |
                            ~wake_lines_sync[WAKE_IDX_RTT];

    // debounced transition on an enabled pin
    assign backup_wake_hit = |(deb_change & wake_pin_enable) | alarm_low_sync;

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer

    lpw_state_type    state;
    lpw_state_type    next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_backup_wake;
    logic             next_main_clk_sel_rc;

    always_comb begin
        next_state           = state;
        next_cnt             = cnt;
        next_backup_wake     = 1'b0;
        next_main_clk_sel_rc = main_clk_sel_rc;
        case (state)
            ST_RUN: begin
                next_cnt = CNT_ZERO;
                if (backup_enter) begin
                    next_state = ST_BACKUP;
                end else if (wait_for_event_instr && low_power_select) begin
                    next_state = ST_WAIT_SYNC;
                end else if (wait_for_interrupt_instr) begin
                    next_state = ST_SLEEP_WFI;
                end else if (wait_for_event_instr) begin
                    next_state = ST_SLEEP_WFE;
                end
            end
            ST_SLEEP_WFI: begin
                if (irq_pending) begin
                    next_state = ST_RUN;
                end
            end
            ST_SLEEP_WFE: begin
                if (event_pending || wait_wake) begin
                    next_state = ST_RUN;
                end
            end
            ST_WAIT_SYNC: begin
                // main clock resync before clocks stop; software polls the enable bit
                if (wait_wake) begin
                    next_state = ST_RESTART;
                    next_cnt   = CNT_ZERO;
                end else if (cnt == CNT_W'(RESYNC_CYC - 1)) begin
                    next_state = ST_WAIT;
                    next_cnt   = CNT_ZERO;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_WAIT: begin
                if (wait_wake) begin
                    next_state = ST_RESTART;
                    next_cnt   = CNT_ZERO;
                end
            end
            ST_RESTART: begin
                // oscillator settle is far inside the startup bound
                if (cnt == CNT_W'(RC_SETTLE_CYC - 1)) begin
                    next_state           = ST_RUN;
                    next_main_clk_sel_rc = 1'b1;
                    next_cnt             = CNT_ZERO;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_BACKUP: begin
                if (backup_wake_hit) begin
                    next_state       = ST_RESTART;
                    next_backup_wake = 1'b1;
                    next_cnt         = CNT_ZERO;
                end
            end
            default: begin
                next_state = ST_RUN;
                next_cnt   = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state           <= ST_RUN;
            cnt             <= CNT_ZERO;
            backup_wake     <= 1'b0;
            main_clk_sel_rc <= 1'b1;
        end else if (clk_en) begin
            state           <= next_state;
            cnt             <= next_cnt;
            backup_wake     <= next_backup_wake;
            main_clk_sel_rc <= next_main_clk_sel_rc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock gating outputs, registered so they never glitch

    logic next_core_clk_en;
    logic next_periph_clk_en;
    logic next_mem_clk_en;
    logic next_rc_osc_on;
    logic next_fast_rc_osc_enable;

    always_comb begin
        next_core_clk_en        = 1'b1;
        next_periph_clk_en      = 1'b1;
        next_mem_clk_en         = 1'b1;
        next_rc_osc_on          = 1'b1;
        next_fast_rc_osc_enable = 1'b1;
        case (next_state)
            ST_SLEEP_WFI, ST_SLEEP_WFE: begin
                next_core_clk_en = 1'b0;
            end
            ST_WAIT_SYNC: begin
                next_fast_rc_osc_enable = 1'b0;  // reads cleared once resync starts
            end
            ST_WAIT, ST_BACKUP: begin
                // supplies stay on, only clocks stop
                next_core_clk_en        = 1'b0;
                next_periph_clk_en      = 1'b0;
                next_mem_clk_en         = 1'b0;
                next_rc_osc_on          = 1'b0;
                next_fast_rc_osc_enable = 1'b0;
            end
            ST_RESTART: begin
                // oscillator back on, core held until settled
                next_core_clk_en   = 1'b0;
                next_periph_clk_en = 1'b0;
                next_mem_clk_en    = 1'b0;
            end
            default: begin
                next_core_clk_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            core_clk_en        <= 1'b1;
            periph_clk_en      <= 1'b1;
            mem_clk_en         <= 1'b1;
            rc_osc_on          <= 1'b1;
            fast_rc_osc_enable <= 1'b1;
        end else if (clk_en) begin
            core_clk_en        <= next_core_clk_en;
            periph_clk_en      <= next_periph_clk_en;
            mem_clk_en         <= next_mem_clk_en;
            rc_osc_on          <= next_rc_osc_on;
            fast_rc_osc_enable <= next_fast_rc_osc_enable;
        end
    end

    // status flags follow the state register
    assign in_sleep  = (state == ST_SLEEP_WFI) || (state == ST_SLEEP_WFE);
    assign in_wait   = (state == ST_WAIT) || (state == ST_WAIT_SYNC);
    assign in_backup = (state == ST_BACKUP);

    ////////////////////////////////////////////////////////////////////////////
    // pad retention and backup-reset defaults

    logic            io_default;
    logic            next_io_default;
    logic [IO_W-1:0] next_io_out;
    logic [IO_W-1:0] next_io_oe;
    logic [IO_W-1:0] next_io_pullup;

    always_comb begin
        next_io_default = io_default;
        next_io_out     = io_out;
        next_io_oe      = io_oe;
        next_io_pullup  = io_pullup;
        if (next_backup_wake) begin
            next_io_default = 1'b1;  // wake from backup acts as backup reset
        end else if (io_release) begin
            next_io_default = 1'b0;
        end
        if (state == ST_BACKUP) begin
            // hold last driven levels
            next_io_out = io_out;
            next_io_oe  = io_oe;
        end else if (next_io_default) begin
            // input with pull-up until software takes the pads
            next_io_out    = '0;
            next_io_oe     = '0;
            next_io_pullup = '1;
        end else begin
            next_io_out    = io_out_req;
            next_io_oe     = io_oe_req;
            next_io_pullup = ~io_oe_req;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            io_default <= 1'b1;
            io_out     <= '0;
            io_oe      <= '0;
            io_pullup  <= '1;
        end else if (clk_en) begin
            io_default <= next_io_default;
            io_out     <= next_io_out;
            io_oe      <= next_io_oe;
            io_pullup  <= next_io_pullup;
        end
    end

endmodule

// file: dv/lpw_top_properties.sv
// Purpose: port checks on the low-power wake controller
// Assumes: bound into lpw_top, one sys_clk domain
// Notes:   bounds follow the hand-over latencies
`timescale 1ns/1ps
module lpw_checker
    import lpw_pkg::*;
#(
    parameter int IO_W = 32
)
(
    // clock, reset, core side
    input wire logic                 sys_clk,
    input wire logic                 rstn,
    input wire logic                 clk_en,
    input wire logic                 wait_for_event_instr,
    input wire logic                 wait_for_interrupt_instr,
    input wire logic                 irq_pending,
    input wire logic                 low_power_select,
    input wire logic                 backup_enter,
    input wire logic                 io_release,
    // wake sources
    input wire logic [NUM_WAKE-1:0]  fast_startup_mode_reg,
    input wire logic [15:0]          fast_wake_lines,
    input wire logic                 supply_monitor_alarm,
    input wire logic                 rtc_alarm,
    input wire logic                 real_time_timer_alarm,
    // outputs
    input wire logic [IO_W-1:0]      io_out,
    input wire logic [IO_W-1:0]      io_oe,
    input wire logic [IO_W-1:0]      io_pullup,
    input wire logic                 core_clk_en,
    input wire logic                 periph_clk_en,
    input wire logic                 mem_clk_en,
    input wire logic                 main_clk_sel_rc,
    input wire logic                 fast_rc_osc_enable,
    input wire logic                 fast_startup_req,
    input wire logic                 in_sleep,
    input wire logic                 in_wait,
    input wire logic                 in_backup,
    input wire logic                 backup_wake
);
    logic run;
    logic by_wfi;
    logic next_by_wfi;
    logic wfe_wait;
    assign run = !in_sleep && !in_wait && !in_backup;
    assign wfe_wait = wait_for_event_instr && low_power_select;
    // which instruction put the core to sleep; ports alone cannot tell
    always_comb begin
        next_by_wfi = by_wfi;
        if (run && clk_en && !backup_enter)
            next_by_wfi = wait_for_interrupt_instr && !wfe_wait;
    end
    always_ff @(posedge sys_clk) begin
        by_wfi <= rstn ? next_by_wfi : 1'b0;
    end
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    wfi_sleep_a: assert property (
        run && clk_en && wait_for_interrupt_instr && !backup_enter && !wfe_wait
        |=> in_sleep && !core_clk_en && periph_clk_en) else $error("wfi did not enter sleep");
    wfe_wait_a: assert property (
        run && clk_en && wfe_wait && !backup_enter |=> in_wait && !fast_rc_osc_enable)
        else $error("wfe did not enter wait");
    wait_clocks_a: assert property (
        (in_wait && clk_en)[*6] |-> !core_clk_en && !periph_clk_en && !mem_clk_en)
        else $error("clocks still on in wait");
    fast_req_a: assert property (
        fast_startup_req == |(fast_startup_mode_reg
        & ~{real_time_timer_alarm, rtc_alarm, supply_monitor_alarm, fast_wake_lines}))
        else $error("start-up request wrong");
    startup_bound_a: assert property (
        in_wait && !core_clk_en && fast_startup_req && clk_en
        |-> ##[1:1000] (core_clk_en && main_clk_sel_rc && !in_wait)) else $error("restart too slow");
    irq_wake_a: assert property (
        in_sleep && by_wfi && irq_pending && clk_en |=> !in_sleep && core_clk_en)
        else $error("irq did not end sleep");
    backup_hold_a: assert property (
        in_backup && $past(in_backup) |-> $stable(io_out) && $stable(io_oe) && $stable(io_pullup))
        else $error("pads moved in backup");
    backup_pads_a: assert property (
        backup_wake ##1 (!io_release)[*2] |-> io_oe == '0 && io_out == '0 && &io_pullup)
        else $error("pads not defaulted after backup wake");
endmodule

bind lpw_top lpw_checker #(.IO_W(IO_W)) i_chk (.sys_clk, .rstn, .clk_en, .wait_for_event_instr,
    .wait_for_interrupt_instr, .irq_pending, .low_power_select, .backup_enter, .io_release,
    .fast_startup_mode_reg, .fast_wake_lines, .supply_monitor_alarm, .rtc_alarm, .real_time_timer_alarm,
    .io_out, .io_oe, .io_pullup, .core_clk_en, .periph_clk_en, .mem_clk_en, .main_clk_sel_rc,
    .fast_rc_osc_enable, .fast_startup_req, .in_sleep, .in_wait, .in_backup, .backup_wake);

// file: dv/lpw_wake_src.sv
// Purpose: model of the external wake pins, alarms and usb wake
// Assumes: levels may change at any time against sys_clk
// Notes:   index 0..18 active low, 19 is usb wake active high
`timescale 1ns/1ps
module lpw_wake_src
    import lpw_pkg::*;
(
    // wake lines toward the block
    output logic [15:0] fast_wake_lines,
    output logic        supply_monitor_alarm,
    output logic        rtc_alarm,
    output logic        real_time_timer_alarm,
    output logic        usb_wake
);
    logic [SYNC_W-1:0] act = '0;
    // pins and alarms are pulled up, so a quiet source reads high
    assign fast_wake_lines = ~act[15:0];
    assign supply_monitor_alarm = ~act[WAKE_IDX_SM];
    assign rtc_alarm = ~act[WAKE_IDX_RTC];
    assign real_time_timer_alarm = ~act[WAKE_IDX_RTT];
    assign usb_wake = act[SYNC_IDX_USB];
    // a request stays until withdrawn, like a held push button
    task automatic drive(input int idx, input logic on);
        act[idx] = on;
    endtask
endmodule

// file: dv/test_low_power_mode_wakeup_control.sv
// Purpose: directed scenarios for sleep, wait, fast restart and backup
// Assumes: inputs change 1 ns after the rising edge
// Notes:   pad width cut to 8 to keep the bench short
`timescale 1ns/1ps
module test_low_power_mode_wakeup_control;
    import lpw_pkg::*;
    localparam int IO_W = 8;
    logic                sys_clk, rstn, clk_en, wait_for_event_instr, wait_for_interrupt_instr;
    logic                irq_pending, event_pending, low_power_select, usb_wake_enable, backup_enter;
    logic                io_release, supply_monitor_alarm, rtc_alarm, real_time_timer_alarm, usb_wake;
    logic                core_clk_en, periph_clk_en, mem_clk_en, rc_osc_on, main_clk_sel_rc;
    logic                fast_rc_osc_enable, fast_startup_req, in_sleep, in_wait, in_backup, backup_wake;
    logic [NUM_WAKE-1:0] fast_startup_mode_reg;
    logic [15:0]         wake_pin_enable, fast_wake_lines;
    logic [7:0]          debounce_limit;
    logic [IO_W-1:0]     io_out_req, io_oe_req, io_out, io_oe, io_pullup;
    int                  num_errors = 0;
    int                  cmp_count = 0;
    int                  cyc = 0;
    lpw_top #(.IO_W(IO_W)) i_dut (.sys_clk, .rstn, .clk_en, .wait_for_event_instr, .wait_for_interrupt_instr,
        .irq_pending, .event_pending, .low_power_select, .fast_startup_mode_reg, .usb_wake_enable,
        .wake_pin_enable, .debounce_limit, .backup_enter, .io_release, .fast_wake_lines,
        .supply_monitor_alarm, .rtc_alarm, .real_time_timer_alarm, .usb_wake, .io_out_req, .io_oe_req,
        .io_out, .io_oe, .io_pullup, .core_clk_en, .periph_clk_en, .mem_clk_en, .rc_osc_on,
        .main_clk_sel_rc, .fast_rc_osc_enable, .fast_startup_req, .in_sleep, .in_wait, .in_backup,
        .backup_wake);
    lpw_wake_src i_src (.fast_wake_lines, .supply_monitor_alarm, .rtc_alarm, .real_time_timer_alarm,
        .usb_wake);
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard; full run needs about 10k cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // wfi sleep ignores events, and a frozen clk_en delays the irq wake
    task automatic sleep_wfi();
        pulse(wait_for_interrupt_instr);
        check("sleep", in_sleep, 1);
        check("core clk", core_clk_en, 0);
        check("periph clk", periph_clk_en, 1);
        pulse(event_pending);
        check("sleep on event", in_sleep, 1);
        clk_en = 1'b0;
        irq_pending = 1'b1;
        step(2);
        check("frozen", in_sleep, 1);
        clk_en = 1'b1;
        step(1);
        irq_pending = 1'b0;
        check("irq wake", in_sleep, 0);
        check("core clk back", core_clk_en, 1);
    endtask
    task automatic sleep_wfe();
        pulse(wait_for_event_instr);
        check("wfe sleep", in_sleep, 1);
        check("wfe no wait", in_wait, 0);
        pulse(event_pending);
        check("event wake", in_sleep, 0);
    endtask
    // every wake source, usb last, ends wait within the startup bound
    task automatic wait_wake();
        int n;
        for (int i = 0; i < SYNC_W; i++) begin
            low_power_select = 1'b1;
            pulse(wait_for_event_instr);
            check("wait", in_wait, 1);
            check("rc enable reads clear", fast_rc_osc_enable, 0);
            step(5);
            check("clocks off", {core_clk_en, periph_clk_en, mem_clk_en}, 0);
            i_src.drive(i, 1'b1);
            #1;
            check("startup req", fast_startup_req, i < NUM_WAKE);
            step(3);
            check("clock held", core_clk_en, 0);
            n = 3;
            while (!(core_clk_en === 1'b1 && main_clk_sel_rc === 1'b1) && n < 1000) begin
                step(1);
                n++;
            end
            check("startup fast", n < STARTUP_MAX_CYC, 1);
            check("osc on", rc_osc_on, 1);
            check("wait ended", in_wait, 0);
            i_src.drive(i, 1'b0);
            low_power_select = 1'b0;
            step(2);
        end
    endtask
    // pads hold in backup; only an enabled pin wakes, then pads default
    task automatic backup_cycle();
        int n;
        io_out_req = 8'ha5;
        io_oe_req = 8'h0f;
        wake_pin_enable = 16'h0008;
        pulse(io_release);
        pulse(backup_enter);
        check("backup", in_backup, 1);
        io_out_req = 8'h00;
        io_oe_req = 8'hff;
        i_src.drive(2, 1'b1);
        step(12);
        check("hold out", io_out, 8'ha5);
        check("hold oe", io_oe, 8'h0f);
        check("no wake", in_backup, 1);
        i_src.drive(3, 1'b1);
        n = 0;
        while (backup_wake !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        check("backup wake", backup_wake, 1);
        step(3);
        check("pad oe", io_oe, 0);
        check("pad pullup", io_pullup, 8'hff);
        pulse(io_release);
        step(1);
        check("released", io_oe, 8'hff);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {rstn, wait_for_event_instr, wait_for_interrupt_instr, irq_pending, event_pending} = '0;
        {low_power_select, backup_enter, io_release} = '0;
        usb_wake_enable = 1'b1;
        clk_en = 1'b1;
        fast_startup_mode_reg = '1;
        wake_pin_enable = '0;
        debounce_limit = 8'h02;
        io_out_req = '0;
        io_oe_req = '0;
        step(3);
        rstn = 1'b1;
        step(1);
        sleep_wfi();
        sleep_wfe();
        wait_wake();
        backup_cycle();
        complete_run();
    end
endmodule
